// *** gpt_timers.sv ***
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
module gpt_timers
	import gpt_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	input  wire logic        idle_i,
	input  wire logic        instr_tick_i,
	input  wire logic        standalone_ext_clock_pin_i,
	input  wire logic [3:0]  pair_ext_clock_pin_i,
	output logic             standalone_flag_o,
	output logic      [3:0]  pair_flag_o,
	output logic             converter_trigger_o,
	output logic      [3:0]  dma_request_o
);

	// all system-clock state lives in one packed struct: control, count, period and prescaler
	// per timer, the pin synchronisers, the async toggle crossing and the
	// registered outputs
	typedef struct packed {
		logic [15:0]      s_ctrl;
		logic [15:0]      s_cnt;
		logic [15:0]      s_per;
		logic [7:0]       s_ps;
		logic             s_flag;
		logic [3:0][15:0] p_ctrl;
		logic [3:0][15:0] p_cnt;
		logic [3:0][15:0] p_per;
		logic [3:0][7:0]  p_ps;
		logic [3:0]       p_flag;
		logic [4:0]       sync1;
		logic [4:0]       sync2;
		logic [4:0]       pin_prev;
		logic             async_tog;
		logic             async_s1;
		logic             async_s2;
		logic             async_prev;
		logic [15:0]      rdata;
		logic             trig;
		logic [3:0]       dma;
	} gpt_state_s;

	gpt_state_s st;
	gpt_state_s next_st;

	// last prescaler count for a two-bit ratio field
	function automatic logic [7:0] ps_last(input logic [1:0] sel);
		case (sel)
			2'b00: ps_last = PS_LAST_1;
			2'b01: ps_last = PS_LAST_8;
			2'b10: ps_last = PS_LAST_64;
			default: ps_last = PS_LAST_256;
		endcase
	endfunction

	// prescaler has reached its last count for the selected ratio; shared by
	// the pin-domain divider, the standalone divider and the four pair dividers
	function automatic logic ps_wrap(input logic [7:0] ps, input logic [1:0] sel);
		ps_wrap = (ps >= ps_last(sel));
	endfunction

	// operating mode from the control word; the gate bit only counts with the
	// internal source and the sync bit only with the pin
	function automatic gpt_mode_e mode_of(input logic [15:0] c);
		if (!c[BIT_SOURCE])
			mode_of = c[BIT_GATE] ? GPT_MODE_GATED : GPT_MODE_TIMER;
		else
			mode_of = c[BIT_SYNC] ? GPT_MODE_SYNC_COUNT : GPT_MODE_ASYNC_COUNT;
	endfunction

	// a timer advances only while its run bit is set and it is not halted in idle
	function automatic logic active(input logic [15:0] c, input logic idle);
		active = c[BIT_RUN] && !(idle && c[BIT_IDLE_HALT]);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// async counter path: the prescaler runs straight on the pin clock, and only
	// its carry crosses back as a toggle, so the unsynchronised mode still counts
	// edges that are shorter than a system clock period
	logic [7:0] async_ps;
	logic       async_en;

	// enable for the pin-domain divider, decoded in the system domain
	assign async_en = (mode_of(st.s_ctrl) == GPT_MODE_ASYNC_COUNT) && active(st.s_ctrl, idle_i);

	// pin-domain divider; its only output is a toggle read through two flops
	// the control bits are read here without a sync: change the mode or ratio
	// only while the counter is stopped or the pin is quiet
	always_ff @(posedge standalone_ext_clock_pin_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			async_ps <= 8'h00;
		end else if (async_en) begin
			async_ps <= ps_wrap(async_ps, st.s_ctrl[BIT_PS_HI:BIT_PS_LO]) ? 8'h00 : async_ps + 8'h01;
		end
	end

	// toggles once per prescaler wrap; a level crossing is safe where a pulse would be lost
	logic async_tog_pin;

	always_ff @(posedge standalone_ext_clock_pin_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			async_tog_pin <= 1'b0;
		end else if (async_en && ps_wrap(async_ps, st.s_ctrl[BIT_PS_HI:BIT_PS_LO])) begin
			async_tog_pin <= ~async_tog_pin;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		logic [4:0]  rise;
		logic        s_tick;
		logic        s_gate_fall;
		logic [15:0] cw;
		logic        wide;
		logic        lo_tick;
		logic        lo_in;
		logic        lo_wrap;
		logic [31:0] cnt32;
		logic [31:0] per32;
		int          lo;
		int          hi;
		logic        s_set;
		logic [3:0]  p_set;

		next_st = st;
		next_st.trig = 1'b0;
		next_st.dma = 4'h0;
		rise = 5'h00;
		s_tick = 1'b0;
		s_gate_fall = 1'b0;
		cw = 16'h0000;
		wide = 1'b0;
		lo_tick = 1'b0;
		lo_in = 1'b0;
		lo_wrap = 1'b0;
		cnt32 = 32'h0;
		per32 = 32'h0;
		lo = 0;
		hi = 0;
		s_set = 1'b0;
		p_set = 4'h0;

		// two-flop sync of pins; edge detect reads only the second stage
		// the gate inputs share these synchronisers, so a gate edge is seen two
		// to three cycles after the pin moves
		next_st.sync1 = {pair_ext_clock_pin_i, standalone_ext_clock_pin_i};
		next_st.sync2 = st.sync1;
		next_st.pin_prev = st.sync2;
		rise = st.sync2 & ~st.pin_prev;
		next_st.async_s1 = async_tog_pin;
		next_st.async_s2 = st.async_s1;
		next_st.async_prev = st.async_s2;

		// standalone timer count input
		if (active(st.s_ctrl, idle_i)) begin
			case (mode_of(st.s_ctrl))
				GPT_MODE_TIMER: begin
					lo_in = instr_tick_i;
				end
				GPT_MODE_GATED: begin
					lo_in = instr_tick_i && st.sync2[0];
					s_gate_fall = !st.sync2[0] && st.pin_prev[0];
				end
				GPT_MODE_SYNC_COUNT: begin
					lo_in = rise[0];
				end
				default: begin
					lo_in = 1'b0;
				end
			endcase
			// the prescaler only moves on a counted input, so a stopped timer
			// keeps its partial prescale
			if (lo_in) begin
				if (ps_wrap(st.s_ps, st.s_ctrl[BIT_PS_HI:BIT_PS_LO])) begin
					next_st.s_ps = 8'h00;
					s_tick = 1'b1; // sync stage sits before the prescaler
				end else begin
					next_st.s_ps = st.s_ps + 8'h01;
				end
			end
			// async mode takes its tick from the toggle crossing; the toggle lags
			// the pin by two to three system clocks
			if (mode_of(st.s_ctrl) == GPT_MODE_ASYNC_COUNT)
				s_tick = st.async_s2 ^ st.async_prev;
		end
		if (s_tick) begin
			if (st.s_cnt == st.s_per) begin
				next_st.s_cnt = 16'h0000;
				s_set = 1'b1; // gated mode flags on a match as well
			end else begin
				next_st.s_cnt = st.s_cnt + 16'h0001;
			end
		end
		if (s_gate_fall)
			s_set = 1'b1;

		// pairs: index 0/1 form pair a, 2/3 pair b
		// in wide mode the low timer's control, prescaler, clock and gate drive
		// both words; the high control is ignored, idle-halt included, and
		// software is still expected to keep that bit clear
		for (int p = 0; p < 2; p++) begin
			lo = 2 * p;
			hi = lo + 1;
			wide = st.p_ctrl[lo][BIT_WIDE];
			for (int t = 0; t < 2; t++) begin
				if (t == 0 || !wide) begin
					cw = st.p_ctrl[lo + t]; // high control ignored when wide
					lo_in = 1'b0;
					lo_tick = 1'b0;
					// the paired timers offer only synchronous inputs, so a pin count is
					// always an edge of the synchronised pin
					if (active(cw, idle_i)) begin
						// only synchronous modes exist here
						if (cw[BIT_SOURCE])
							lo_in = rise[lo + t + 1];
						else if (cw[BIT_GATE])
							lo_in = instr_tick_i && st.sync2[lo + t + 1];
						else
							lo_in = instr_tick_i;
						if (!cw[BIT_SOURCE] && cw[BIT_GATE] && !st.sync2[lo + t + 1] && st.pin_prev[lo + t + 1])
							p_set[wide ? hi : lo + t] = 1'b1;
					end
					if (lo_in) begin
						if (ps_wrap(st.p_ps[lo + t], cw[BIT_PS_HI:BIT_PS_LO])) begin
							next_st.p_ps[lo + t] = 8'h00;
							lo_tick = 1'b1;
						end else begin
							next_st.p_ps[lo + t] = st.p_ps[lo + t] + 8'h01;
						end
					end
					// the carry is done on the joined value, so the high word steps in
					// the same cycle in which the low word wraps
					if (lo_tick && wide) begin
						cnt32 = {st.p_cnt[hi], st.p_cnt[lo]};
						per32 = {st.p_per[hi], st.p_per[lo]};
						lo_wrap = (cnt32 == per32);
						cnt32 = lo_wrap ? 32'h0 : cnt32 + 32'h1;
						next_st.p_cnt[lo] = cnt32[15:0];
						next_st.p_cnt[hi] = cnt32[31:16];
						if (lo_wrap) begin
							p_set[hi] = 1'b1;
							next_st.dma[hi] = 1'b1;
							next_st.trig = next_st.trig | (p == 0);
						end
					end else if (lo_tick) begin
						lo_wrap = (st.p_cnt[lo + t] == st.p_per[lo + t]);
						next_st.p_cnt[lo + t] = lo_wrap ? 16'h0000 : st.p_cnt[lo + t] + 16'h0001;
						if (lo_wrap) begin
							p_set[lo + t] = 1'b1;
							next_st.dma[lo + t] = 1'b1;
							if (p == 0 && t == 1)
								next_st.trig = 1'b1;
						end
					end
				end
			end
		end

		// hardware sets are gathered first so that a clear in the same cycle
		// can never hide them
		next_st.s_flag = st.s_flag | s_set;
		next_st.p_flag = st.p_flag | p_set;

		// word map: 0 standalone control, 1 count, 2 period; 3..6 pair controls
		// (a low, a high, b low, b high); 7..A pair counts; B..E pair periods;
		// F flags, bit 0 standalone and bits 4:1 the four paired timers
		// register writes; a hardware set in the same cycle wins over the clear
		if (wr_i) begin
			case (addr_i)
				ADDR_STANDALONE_CONTROL: next_st.s_ctrl = wdata_i & MASK_STANDALONE;
				ADDR_STANDALONE_COUNT: begin
					if (!(st.s_ctrl[BIT_RUN] && mode_of(st.s_ctrl) == GPT_MODE_SYNC_COUNT))
						next_st.s_cnt = wdata_i;
				end
				ADDR_STANDALONE_PERIOD: next_st.s_per = wdata_i;
				ADDR_PAIR_A_LOW_CONTROL: next_st.p_ctrl[0] = wdata_i & MASK_PAIR_LOW;
				ADDR_PAIR_A_HIGH_CONTROL: next_st.p_ctrl[1] = wdata_i & MASK_PAIR_HIGH;
				ADDR_PAIR_B_LOW_CONTROL: next_st.p_ctrl[2] = wdata_i & MASK_PAIR_LOW;
				ADDR_PAIR_B_HIGH_CONTROL: next_st.p_ctrl[3] = wdata_i & MASK_PAIR_HIGH;
				ADDR_PAIR_A_LOW_COUNT: next_st.p_cnt[0] = wdata_i;
				ADDR_PAIR_A_HIGH_COUNT: next_st.p_cnt[1] = wdata_i;
				ADDR_PAIR_B_LOW_COUNT: next_st.p_cnt[2] = wdata_i;
				ADDR_PAIR_B_HIGH_COUNT: next_st.p_cnt[3] = wdata_i;
				ADDR_PAIR_A_LOW_PERIOD: next_st.p_per[0] = wdata_i;
				ADDR_PAIR_A_HIGH_PERIOD: next_st.p_per[1] = wdata_i;
				ADDR_PAIR_B_LOW_PERIOD: next_st.p_per[2] = wdata_i;
				ADDR_PAIR_B_HIGH_PERIOD: next_st.p_per[3] = wdata_i;
				default: begin
					// write-one-to-clear; a set in this same cycle still wins
					next_st.s_flag = (st.s_flag & ~wdata_i[0]) | s_set;
					next_st.p_flag = (st.p_flag & ~wdata_i[4:1]) | p_set;
				end
			endcase
		end

		// read data stands the cycle after the strobe only
		// returning zero between reads keeps the bus quiet for an or-combined mux
		next_st.rdata = 16'h0000;
		if (rd_i) begin
			case (addr_i)
				ADDR_STANDALONE_CONTROL: next_st.rdata = st.s_ctrl;
				ADDR_STANDALONE_COUNT: next_st.rdata = st.s_cnt;
				ADDR_STANDALONE_PERIOD: next_st.rdata = st.s_per;
				ADDR_PAIR_A_LOW_CONTROL: next_st.rdata = st.p_ctrl[0];
				ADDR_PAIR_A_HIGH_CONTROL: next_st.rdata = st.p_ctrl[1];
				ADDR_PAIR_B_LOW_CONTROL: next_st.rdata = st.p_ctrl[2];
				ADDR_PAIR_B_HIGH_CONTROL: next_st.rdata = st.p_ctrl[3];
				ADDR_PAIR_A_LOW_COUNT: next_st.rdata = st.p_cnt[0];
				ADDR_PAIR_A_HIGH_COUNT: next_st.rdata = st.p_cnt[1];
				ADDR_PAIR_B_LOW_COUNT: next_st.rdata = st.p_cnt[2];
				ADDR_PAIR_B_HIGH_COUNT: next_st.rdata = st.p_cnt[3];
				ADDR_PAIR_A_LOW_PERIOD: next_st.rdata = st.p_per[0];
				ADDR_PAIR_A_HIGH_PERIOD: next_st.rdata = st.p_per[1];
				ADDR_PAIR_B_LOW_PERIOD: next_st.rdata = st.p_per[2];
				ADDR_PAIR_B_HIGH_PERIOD: next_st.rdata = st.p_per[3];
				default: next_st.rdata = {11'h000, st.p_flag, st.s_flag};
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	// periods reset to all ones so a timer that is only started runs the full range
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st <= '0;
			st.s_ctrl <= RESET_CONTROL;
			st.s_cnt <= RESET_COUNT;
			st.s_per <= RESET_PERIOD;
			st.p_per <= {4{RESET_PERIOD}};
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from flops
	// triggers and dma requests are one-cycle pulses, one cycle after the wrapping tick
	assign rdata_o = st.rdata;
	assign standalone_flag_o = st.s_flag;
	assign pair_flag_o = st.p_flag;
	assign converter_trigger_o = st.trig;
	assign dma_request_o = st.dma;

endmodule // gpt_timers

// *** gpt_pkg.sv ***
package gpt_pkg;

	// register offsets (word index on the plain port)
	localparam logic [3:0] ADDR_STANDALONE_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_STANDALONE_COUNT   = 4'h1;
	localparam logic [3:0] ADDR_STANDALONE_PERIOD  = 4'h2;
	localparam logic [3:0] ADDR_PAIR_A_LOW_CONTROL = 4'h3;
	localparam logic [3:0] ADDR_PAIR_A_HIGH_CONTROL = 4'h4;
	localparam logic [3:0] ADDR_PAIR_B_LOW_CONTROL = 4'h5;
	localparam logic [3:0] ADDR_PAIR_B_HIGH_CONTROL = 4'h6;
	localparam logic [3:0] ADDR_PAIR_A_LOW_COUNT   = 4'h7;
	localparam logic [3:0] ADDR_PAIR_A_HIGH_COUNT  = 4'h8;
	localparam logic [3:0] ADDR_PAIR_B_LOW_COUNT   = 4'h9;
	localparam logic [3:0] ADDR_PAIR_B_HIGH_COUNT  = 4'hA;
	localparam logic [3:0] ADDR_PAIR_A_LOW_PERIOD  = 4'hB;
	localparam logic [3:0] ADDR_PAIR_A_HIGH_PERIOD = 4'hC;
	localparam logic [3:0] ADDR_PAIR_B_LOW_PERIOD  = 4'hD;
	localparam logic [3:0] ADDR_PAIR_B_HIGH_PERIOD = 4'hE;
	localparam logic [3:0] ADDR_FLAGS              = 4'hF;

	// control field positions
	localparam int BIT_RUN       = 15;
	localparam int BIT_IDLE_HALT = 13;
	localparam int BIT_GATE      = 6;
	localparam int BIT_PS_HI     = 5;
	localparam int BIT_PS_LO     = 4;
	localparam int BIT_WIDE      = 3;
	localparam int BIT_SYNC      = 2;
	localparam int BIT_SOURCE    = 1;

	// writable masks; all other control bits read as zero
	localparam logic [15:0] MASK_STANDALONE = 16'hA076;
	localparam logic [15:0] MASK_PAIR_LOW   = 16'hA07A;
	localparam logic [15:0] MASK_PAIR_HIGH  = 16'hA072;

	// reset values
	localparam logic [15:0] RESET_CONTROL = 16'h0000;
	localparam logic [15:0] RESET_COUNT   = 16'h0000;
	localparam logic [15:0] RESET_PERIOD  = 16'hFFFF;

	// prescale ratios
	localparam logic [7:0] PS_LAST_1   = 8'h00;
	localparam logic [7:0] PS_LAST_8   = 8'h07;
	localparam logic [7:0] PS_LAST_64  = 8'h3F;
	localparam logic [7:0] PS_LAST_256 = 8'hFF;

	// standalone operating modes
	typedef enum logic [1:0] {
		GPT_MODE_TIMER,
		GPT_MODE_GATED,
		GPT_MODE_SYNC_COUNT,
		GPT_MODE_ASYNC_COUNT
	} gpt_mode_e;

endpackage

// *** gpt_timers_chk.sv ***
`timescale 1ns/1ps
module gpt_chk
	import gpt_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	input wire logic [3:0]  addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic        idle_i,
	input wire logic        standalone_flag_o,
	input wire logic [3:0]  pair_flag_o,
	input wire logic        converter_trigger_o,
	input wire logic [3:0]  dma_request_o
);
	logic [15:0] ctl;
	// shadow of the standalone control; only run and idle-halt are used
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			ctl <= 16'h0000;
		else if (wr_i && addr_i == ADDR_STANDALONE_CONTROL)
			ctl <= wdata_i;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// four quiet cycles cover the tick-to-flag pipeline
	sequence s_halted;
		(!ctl[BIT_RUN] || (idle_i && ctl[BIT_IDLE_HALT]))[*4];
	endsequence
	property p_rd_quiet; !rd_i |=> rdata_o == 16'h0000; endproperty
	property p_mask_sa; rd_i && addr_i == ADDR_STANDALONE_CONTROL |=> (rdata_o & ~MASK_STANDALONE) == 16'h0000; endproperty
	property p_mask_lo;
		rd_i && (addr_i == ADDR_PAIR_A_LOW_CONTROL || addr_i == ADDR_PAIR_B_LOW_CONTROL)
		|=> (rdata_o & ~MASK_PAIR_LOW) == 16'h0000;
	endproperty
	property p_mask_hi;
		rd_i && (addr_i == ADDR_PAIR_A_HIGH_CONTROL || addr_i == ADDR_PAIR_B_HIGH_CONTROL)
		|=> (rdata_o & ~MASK_PAIR_HIGH) == 16'h0000;
	endproperty
	property p_trig_a; converter_trigger_o |-> dma_request_o[1]; endproperty
	property p_stop; s_halted |-> !$rose(standalone_flag_o); endproperty
	property p_sa_sticky; standalone_flag_o && !(wr_i && addr_i == ADDR_FLAGS) |=> standalone_flag_o; endproperty
	property p_pair_sticky;
		!(wr_i && addr_i == ADDR_FLAGS) |=> (pair_flag_o & $past(pair_flag_o)) == $past(pair_flag_o);
	endproperty
	property p_dma_flag; dma_request_o[3] |-> ##[0:1] pair_flag_o[3]; endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data not idle");
	a_mask_sa: assert property (p_mask_sa) else $error("standalone control reserved bit set");
	a_mask_lo: assert property (p_mask_lo) else $error("pair low control reserved bit set");
	a_mask_hi: assert property (p_mask_hi) else $error("pair high control reserved bit set");
	a_trig_a: assert property (p_trig_a) else $error("converter trigger not from pair a");
	a_stop: assert property (p_stop) else $error("standalone flag rose while halted");
	a_sa_sticky: assert property (p_sa_sticky) else $error("standalone flag dropped");
	a_pair_sticky: assert property (p_pair_sticky) else $error("pair flag dropped");
	a_dma_flag: assert property (p_dma_flag) else $error("dma pulse without flag");
endmodule // gpt_chk

// *** tb_general_purpose_timers.sv ***
`timescale 1ns/1ps
module tb_general_purpose_timers;
	import gpt_pkg::*;
	logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, idle = 1'b0, tick = 1'b0, pin = 1'b0;
	logic [3:0]  addr = 4'h0, ppin = 4'h0, pflag, dma;
	logic [15:0] wdata = 16'h0000, rdata;
	logic        sflag, trig;
	int          n_fail = 0, samples_checked = 0, seed = 17, n_trig = 0, n_dma [4] = '{0, 0, 0, 0};
	logic [3:0]  ctl_a [5] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6};
	logic [15:0] d;
	gpt_timers u_dut (.clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .idle_i(idle), .instr_tick_i(tick), .standalone_ext_clock_pin_i(pin),
		.pair_ext_clock_pin_i(ppin), .standalone_flag_o(sflag), .pair_flag_o(pflag),
		.converter_trigger_o(trig), .dma_request_o(dma));
	always #2.5 clk = ~clk;
	// pulse tallies for the event outputs
	always @(posedge clk) begin
		n_trig += int'(trig === 1'b1);
		for (int i = 0; i < 4; i++) n_dma[i] += int'(dma[i] === 1'b1);
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [15:0] mask_of(input logic [3:0] a);
		return (a == 4'h0) ? MASK_STANDALONE : (a == 4'h3 || a == 4'h5) ? MASK_PAIR_LOW : MASK_PAIR_HIGH;
	endfunction
	function automatic logic [15:0] exp_reset(input logic [3:0] a);
		return (a == 4'h2 || (a >= 4'hB && a <= 4'hE)) ? RESET_PERIOD : 16'h0000;
	endfunction
	// prescale ratio for a two-bit select: 1, 8, 64, 256
	function automatic int ratio(input int ps);
		return (ps == 3) ? 256 : (1 << (3 * ps));
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic do_reset();
		rst_b <= 1'b0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
	endtask
	// one-cycle strobes, a quiet cycle between accesses
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, exp);
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk) tick <= 1'b1;
			@(posedge clk) tick <= 0;
		end
		repeat (4) @(posedge clk);
	endtask
	// slow pin edges, well apart for the two-flop synchroniser
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge clk) pin <= 1'b1;
			repeat (4) @(posedge clk);
			pin <= 1'b0;
			repeat (4) @(posedge clk);
		end
		repeat (8) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		do_reset();
		for (int a = 0; a < 16; a++) rd_reg(4'(a), exp_reset(4'(a)));
		foreach (ctl_a[i]) begin
			for (int k = 0; k < 4; k++) begin
				d = (k == 0) ? 16'hFFFF : 16'($random(seed));
				wr_reg(ctl_a[i], d);
				rd_reg(ctl_a[i], d & mask_of(ctl_a[i]));
			end
		end
		$display("test registers done");
		for (int ps = 0; ps < 4; ps++) begin
			do_reset();
			wr_reg(ADDR_STANDALONE_PERIOD, 16'h0002);
			wr_reg(ADDR_STANDALONE_CONTROL, 16'h8000 | 16'(ps << 4));
			ticks(3 * ratio(ps) - 1);
			rd_reg(ADDR_STANDALONE_COUNT, 16'h0002);
			chk(16'(sflag), 16'h0000);
			ticks(1);
			rd_reg(ADDR_STANDALONE_COUNT, 16'h0000);
			chk(16'(sflag), 16'h0001);
		end
		$display("test prescale done");
		do_reset();
		wr_reg(ADDR_STANDALONE_CONTROL, 16'hA004);
		idle <= 1'b1;
		ticks(5);
		rd_reg(ADDR_STANDALONE_COUNT, 16'h0000);
		@(posedge clk) idle <= 1'b0;
		ticks(5);
		rd_reg(ADDR_STANDALONE_COUNT, 16'h0005);
		wr_reg(ADDR_STANDALONE_CONTROL, 16'h0000);
		ticks(5);
		rd_reg(ADDR_STANDALONE_COUNT, 16'h0005);
		wr_reg(ADDR_STANDALONE_CONTROL, 16'h8000);
		idle <= 1'b1;
		ticks(3);
		rd_reg(ADDR_STANDALONE_COUNT, 16'h0008);
		@(posedge clk) idle <= 1'b0;
		$display("test run and idle done");
		wr_reg(ADDR_STANDALONE_CONTROL, 16'h8006);
		tick <= 1'b1;
		pulses(5);
		tick <= 1'b0;
		rd_reg(ADDR_STANDALONE_COUNT, 16'h000D);
		wr_reg(ADDR_STANDALONE_COUNT, 16'h1234);
		rd_reg(ADDR_STANDALONE_COUNT, 16'h000D);
		wr_reg(ADDR_STANDALONE_CONTROL, 16'h8002);
		pulses(5);
		rd_reg(ADDR_STANDALONE_COUNT, 16'h0012);
		wr_reg(ADDR_STANDALONE_CONTROL, 16'h0000);
		wr_reg(ADDR_STANDALONE_COUNT, 16'h1234);
		rd_reg(ADDR_STANDALONE_COUNT, 16'h1234);
		$display("test counters done");
		do_reset();
		wr_reg(ADDR_STANDALONE_CONTROL, 16'h8040);
		pin <= 1'b1;
		repeat (4) @(posedge clk);
		ticks(6);
		pin <= 1'b0;
		repeat (8) @(posedge clk);
		rd_reg(ADDR_STANDALONE_COUNT, 16'h0006);
		chk(16'(sflag), 16'h0001);
		wr_reg(ADDR_FLAGS, 16'hFFFF);
		@(negedge clk);
		chk(16'(sflag), 16'h0000);
		$display("test gated done");
		wr_reg(ADDR_PAIR_A_LOW_PERIOD, 16'h0001);
		wr_reg(ADDR_PAIR_A_HIGH_PERIOD, 16'h0000);
		wr_reg(ADDR_PAIR_A_HIGH_CONTROL, 16'h8030);
		wr_reg(ADDR_PAIR_A_LOW_CONTROL, 16'h8008);
		ticks(2);
		wr_reg(ADDR_PAIR_B_HIGH_PERIOD, 16'h0000);
		wr_reg(ADDR_PAIR_B_HIGH_CONTROL, 16'h8000);
		ticks(1);
		@(negedge clk);
		chk(16'(pflag), 16'h000A);
		chk(16'(n_trig), 16'h0001);
		chk({n_dma[0][3:0], n_dma[1][3:0], n_dma[2][3:0], n_dma[3][3:0]}, 16'h0101);
		wr_reg(ADDR_PAIR_A_LOW_CONTROL, 16'h0008);
		wr_reg(ADDR_PAIR_A_LOW_PERIOD, 16'hFFFF);
		wr_reg(ADDR_PAIR_A_HIGH_PERIOD, 16'h0001);
		wr_reg(ADDR_PAIR_A_LOW_COUNT, 16'hFFFE);
		wr_reg(ADDR_PAIR_A_LOW_CONTROL, 16'h8008);
		ticks(3);
		rd_reg(ADDR_PAIR_A_LOW_COUNT, 16'h0001);
		rd_reg(ADDR_PAIR_A_HIGH_COUNT, 16'h0001);
		// wide pin counter with the gate bit set; the high pin must be ignored
		wr_reg(ADDR_PAIR_A_LOW_CONTROL, 16'h804A);
		repeat (3) begin
			@(posedge clk) ppin <= 4'h3;
			repeat (4) @(posedge clk);
			ppin <= 4'h0;
			repeat (4) @(posedge clk);
		end
		repeat (8) @(posedge clk);
		rd_reg(ADDR_PAIR_A_LOW_COUNT, 16'h0004);
		rd_reg(ADDR_PAIR_A_HIGH_COUNT, 16'h0001);
		$display("test pairs done");
		close_out();
	end
	// watchdog well beyond the expected run length
	initial begin
		repeat (40000) @(posedge clk);
		n_fail++;
		close_out();
	end
endmodule // tb_general_purpose_timers
bind gpt_timers gpt_chk u_chk (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .idle_i,
	.standalone_flag_o, .pair_flag_o, .converter_trigger_o, .dma_request_o);
